// ===== eeprom_spi_pkg.sv
// constants and types shared by the serial memory slave and its helpers
package eeprom_spi_pkg;

    // ------------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 13;
    localparam int MEM_BYTES  = 8192;
    localparam int PAGE_BYTES = 32;
    localparam int COL_W      = 5;

    // ------------------------------------------------------------------
    // instruction codes, compared after masking the don't-care bit
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_MASK         = 8'hF7;
    localparam logic [7:0] OPC_SET_LATCH    = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH    = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_READ_ARRAY   = 8'h03;
    localparam logic [7:0] OPC_WRITE_ARRAY  = 8'h02;

    // ------------------------------------------------------------------
    // status byte layout and values
    // ------------------------------------------------------------------
    localparam int         ST_BUSY_BIT     = 0;
    localparam int         ST_WEL_BIT      = 1;
    localparam int         ST_BP_LO_BIT    = 2;
    localparam int         ST_BP_HI_BIT    = 3;
    localparam int         ST_PPE_BIT      = 7;
    localparam logic [7:0] STATUS_BUSY_VAL = 8'hFF;

    // ------------------------------------------------------------------
    // protected region bases and values after reset
    // ------------------------------------------------------------------
    localparam logic [12:0] PROT_QUARTER_BASE = 13'h1800;
    localparam logic [12:0] PROT_HALF_BASE    = 13'h1000;
    localparam logic [1:0]  RST_BP            = 2'h0;
    localparam logic        RST_PPE           = 1'b0;
    localparam logic        RST_WEL           = 1'b0;
    localparam logic        RST_CS_N          = 1'b1;

    // ------------------------------------------------------------------
    // bit counter marks within a byte
    // ------------------------------------------------------------------
    localparam logic [2:0] BIT_SEVENTH = 3'h6;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] BIT_FIRST   = 3'h0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 10;
    localparam int T_WRITE_MS     = 5;
    localparam int WRITE_CYCLES   = T_WRITE_MS * 1000000 / MCLK_PERIOD_NS;

    // command framing states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_OPC     = 3'b001,
        ST_ADDR_HI = 3'b011,
        ST_ADDR_LO = 3'b010,
        ST_DATA    = 3'b110,
        ST_SKIP    = 3'b111
    } cmd_state_t;

endpackage

// ===== eeprom_sync2.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
module eeprom_sync2 #(
    parameter int W = 1
) (
    // clock
    input  wire logic         i_clk,
    // asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // first stage feeds only the second
    always_comb begin
        next_s.meta = i_d;
        next_s.q    = s.meta;
    end

    always_ff @(posedge i_clk) begin
        s <= next_s;
    end

    assign o_q = s.q;

endmodule // eeprom_sync2

// ===== eeprom_array.sv
// byte-wide storage array with one write port and two read ports
`timescale 1ns/10ps
module eeprom_array
    import eeprom_spi_pkg::*;
(
    // clock
    input  wire logic              i_clk,
    // write port
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_waddr,
    input  wire logic [7:0]        i_wdata,
    // read ports, combinational
    input  wire logic [ADDR_W-1:0] i_raddr_a,
    input  wire logic [ADDR_W-1:0] i_raddr_b,
    output logic      [7:0]        o_rdata_a,
    output logic      [7:0]        o_rdata_b
);

    logic [7:0] mem [MEM_BYTES];

    // one byte programmed per cycle
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata_a = mem[i_raddr_a];
    assign o_rdata_b = mem[i_raddr_b];

endmodule // eeprom_array

// ===== eeprom_spi_slave.sv
// serial slave front end of an 8 Kbyte nonvolatile byte memory
`timescale 1ns/10ps

// Operation
// - all fields shift most significant bit first
// - works in clock modes 0 and 3
// - sample on rising, drive on falling edge
// - select rising ends command, launches write
// - select high: standby, output floats
// - first byte after select falls is opcode
// - hardware lock freezes protect bits
// - suspend low pauses sequence, later resumes
// - suspend held high never engages
// - 8192 bytes in 32-byte pages
// - one to 32 bytes per page write
// - self-timed write ends within 5 ms
// - protect upper quarter, half or all
// - reset ignores commands, then standby
// - six opcodes, array commands carry 16-bit address
// - status: busy, latch, protect field, enable
// - only status read accepted while busy
// - latch cleared on reset and after modifying commands
module eeprom_spi_slave
    import eeprom_spi_pkg::*;
#(
    parameter int WR_CYCLES = WRITE_CYCLES
) (
    // system clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // serial link pins
    input  wire logic       i_cs_n,
    input  wire logic       i_sck,
    input  wire logic       i_si,
    output logic            o_so,
    output logic            o_so_oe,
    // control pins
    input  wire logic       i_hold_n,
    input  wire logic       i_wp_n,
    // status out
    output logic            o_busy,
    output logic            o_write_latch,
    output logic [1:0]      o_block_protect,
    output logic            o_protect_pin_enable
);

    // ------------------------------------------------------------------
    // link side state, clocked by the serial clock
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] rx_byte;
    } link_rx_t;

    typedef struct packed {
        logic byte_tgl;
        logic seven_tgl;
    } link_tgl_t;

    typedef struct packed {
        logic [7:0] tx_sh;
        logic       oe;
    } link_tx_t;

    typedef struct packed {
        cmd_state_t       st;
        logic [7:0]       op;
        logic [12:0]      addr;
        logic [4:0]       col;
        logic [7:0]       page;
        logic [7:0]       stat_in;
        logic             got_stat;
        logic [31:0][7:0] pbuf;
        logic [31:0]      pmask;
        logic             wel;
        logic [1:0]       bp;
        logic             protect_pin_enable;
        logic             busy;
        logic [5:0]       wr_idx;
        logic [19:0]      wr_cnt;
        logic [7:0]       tx_even;
        logic [7:0]       tx_odd;
        logic             byte_prev;
        logic             seven_prev;
        logic             cs_prev;
        logic             mem_we;
        logic [12:0]      mem_waddr;
        logic [7:0]       mem_wdata;
    } core_t;

    link_rx_t  lr;
    link_rx_t  next_lr;
    link_tgl_t lt;
    link_tgl_t next_lt;
    link_tx_t  lx;
    link_tx_t  next_lx;
    core_t     c;
    core_t     next_c;

    logic [3:0]  sync_q;
    logic        cs_s;
    logic        wp_s;
    logic        byte_ev;
    logic        seven_ev;
    logic        cs_rise;
    logic [12:0] rd_a;
    logic [12:0] rd_b;
    logic [7:0]  mem_a;
    logic [7:0]  mem_b;

    // upper region lock by protect field
    function automatic logic page_locked(input logic [1:0] bp, input logic [12:0] a);
        case (bp)
            2'h1:    page_locked = (a >= PROT_QUARTER_BASE);
            2'h2:    page_locked = (a >= PROT_HALF_BASE);
            2'h3:    page_locked = 1'b1;
            default: page_locked = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // receive shifter: rising edge, held while suspended
    // ------------------------------------------------------------------
    always_comb begin
        next_lr = lr;
        next_lt = lt;
        if (i_hold_n) begin
            next_lr.shreg  = {lr.shreg[6:0], i_si};
            next_lr.bitcnt = lr.bitcnt + 3'h1;
            if (lr.bitcnt == BIT_LAST) begin
                next_lr.rx_byte  = {lr.shreg[6:0], i_si};
                next_lt.byte_tgl = ~lt.byte_tgl;
            end
            if (lr.bitcnt == BIT_SEVENTH) begin
                next_lt.seven_tgl = ~lt.seven_tgl;
            end
        end
    end

    // select high clears the frame, clock may stand still afterwards
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            lr <= '0;
        end else begin
            lr <= next_lr;
        end
    end

    // event toggles survive the frame end, cleared only by reset
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            lt <= '0;
        end else begin
            lt <= next_lt;
        end
    end

    // ------------------------------------------------------------------
    // transmit shifter: falling edge, byte picked by last received bit
    // ------------------------------------------------------------------
    always_comb begin
        next_lx    = lx;
        next_lx.oe = i_hold_n;
        if (i_hold_n) begin
            if (lr.bitcnt == BIT_FIRST) begin
                next_lx.tx_sh = lr.shreg[0] ? c.tx_odd : c.tx_even;
            end else begin
                next_lx.tx_sh = {lx.tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            lx <= '0;
        end else begin
            lx <= next_lx;
        end
    end

    assign o_so    = lx.tx_sh[7];
    assign o_so_oe = lx.oe;

    // ------------------------------------------------------------------
    // crossings into the system clock
    // ------------------------------------------------------------------
    eeprom_sync2 #(
        .W (4)
    ) u_sync (
        .i_clk (i_mclk),
        .i_d   ({i_cs_n, i_wp_n, lt.byte_tgl, lt.seven_tgl}),
        .o_q   (sync_q)
    );

    assign cs_s     = sync_q[3];
    assign wp_s     = sync_q[2];
    assign byte_ev  = sync_q[1] ^ c.byte_prev;
    assign seven_ev = sync_q[0] ^ c.seven_prev;
    assign cs_rise  = cs_s & ~c.cs_prev;

    // read candidates: both low-bit choices during address, else next byte
    assign rd_a = (c.st == ST_ADDR_LO) ? {c.addr[12:8], lr.shreg[6:0], 1'b0} : 13'(c.addr + 13'h0001);
    assign rd_b = {rd_a[12:1], 1'b1};

    eeprom_array u_array (
        .i_clk     (i_mclk),
        .i_we      (c.mem_we),
        .i_waddr   (c.mem_waddr),
        .i_wdata   (c.mem_wdata),
        .i_raddr_a (rd_a),
        .i_raddr_b (rd_b),
        .o_rdata_a (mem_a),
        .o_rdata_b (mem_b)
    );

    // ------------------------------------------------------------------
    // command decode, status and self-timed write
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] status;
        status = '0;
        status[ST_WEL_BIT]   = c.wel;
        status[ST_BP_LO_BIT] = c.bp[0];
        status[ST_BP_HI_BIT] = c.bp[1];
        status[ST_PPE_BIT]   = c.protect_pin_enable;
        if (c.busy) begin
            status = STATUS_BUSY_VAL;
        end
        next_c            = c;
        next_c.mem_we     = 1'b0;
        next_c.byte_prev  = sync_q[1];
        next_c.seven_prev = sync_q[0];
        next_c.cs_prev    = cs_s;
        // write engine: program buffered bytes, then wait out the cycle
        if (c.busy) begin
            next_c.wr_cnt = c.wr_cnt + 20'h00001;
            if (!c.wr_idx[5]) begin
                next_c.mem_we    = c.pmask[c.wr_idx[4:0]];
                next_c.mem_waddr = {c.page, c.wr_idx[4:0]};
                next_c.mem_wdata = c.pbuf[c.wr_idx[4:0]];
                next_c.wr_idx    = c.wr_idx + 6'h01;
            end
            if (c.wr_cnt == 20'(WR_CYCLES - 1)) begin
                next_c.busy = 1'b0;
            end
        end
        // completed bytes
        if (byte_ev) begin
            case (c.st)
                ST_OPC: begin
                    next_c.op       = lr.rx_byte & OPC_MASK;
                    next_c.got_stat = 1'b0;
                    if (!c.busy) begin
                        next_c.pmask = '0;
                    end
                    if (c.busy && next_c.op != OPC_READ_STATUS) begin
                        next_c.st = ST_SKIP;
                    end else begin
                        case (next_c.op)
                            OPC_READ_ARRAY, OPC_WRITE_ARRAY: next_c.st = ST_ADDR_HI;
                            OPC_SET_LATCH, OPC_CLR_LATCH,
                            OPC_READ_STATUS, OPC_WRITE_STATUS: next_c.st = ST_DATA;
                            default: next_c.st = ST_SKIP;
                        endcase
                    end
                end
                ST_ADDR_HI: begin
                    next_c.addr[12:8] = lr.rx_byte[4:0];
                    next_c.st         = ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    next_c.addr[7:0] = lr.rx_byte;
                    next_c.page      = {c.addr[12:8], lr.rx_byte[7:5]};
                    next_c.col       = lr.rx_byte[4:0];
                    next_c.st        = ST_DATA;
                end
                ST_DATA: begin
                    if (c.op == OPC_WRITE_ARRAY) begin
                        next_c.pbuf[c.col]  = lr.rx_byte;
                        next_c.pmask[c.col] = 1'b1;
                        next_c.col          = c.col + 5'h01;
                    end
                    if (c.op == OPC_WRITE_STATUS && !c.got_stat) begin
                        next_c.stat_in  = lr.rx_byte;
                        next_c.got_stat = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // seven bits in: stage the next outgoing byte
        if (seven_ev && c.st != ST_IDLE) begin
            if (c.st == ST_ADDR_LO && c.op == OPC_READ_ARRAY) begin
                next_c.tx_even = mem_a;
                next_c.tx_odd  = mem_b;
            end else if (c.st == ST_DATA && c.op == OPC_READ_ARRAY) begin
                next_c.tx_even = mem_a;
                next_c.tx_odd  = mem_a;
                next_c.addr    = rd_a;
            end else begin
                next_c.tx_even = status;
                next_c.tx_odd  = status;
            end
        end
        // select falling opens a frame
        if (!cs_s && c.cs_prev && c.st == ST_IDLE) begin
            next_c.st = ST_OPC;
        end
        // select rising ends the command and commits it
        if (cs_rise) begin
            if (next_c.st == ST_DATA) begin
                case (next_c.op)
                    OPC_SET_LATCH: next_c.wel = 1'b1;
                    OPC_CLR_LATCH: next_c.wel = 1'b0;
                    OPC_WRITE_STATUS: begin
                        if (c.wel && next_c.got_stat) begin
                            if (!(c.protect_pin_enable && !wp_s)) begin
                                next_c.bp   = {next_c.stat_in[ST_BP_HI_BIT], next_c.stat_in[ST_BP_LO_BIT]};
                                next_c.protect_pin_enable = next_c.stat_in[ST_PPE_BIT];
                            end
                            next_c.busy   = 1'b1;
                            next_c.wr_idx = 6'h00;
                            next_c.wr_cnt = 20'h00000;
                        end
                        next_c.wel = 1'b0;
                    end
                    OPC_WRITE_ARRAY: begin
                        if (c.wel && |next_c.pmask && !page_locked(c.bp, {next_c.page, 5'h00})) begin
                            next_c.busy   = 1'b1;
                            next_c.wr_idx = 6'h00;
                            next_c.wr_cnt = 20'h00000;
                        end
                        next_c.wel = 1'b0;
                    end
                    default: ;
                endcase
            end
            next_c.st = ST_IDLE;
        end
        // reset: standby with the latch cleared
        if (i_rst) begin
            next_c         = '0;
            next_c.st      = ST_IDLE;
            next_c.wel     = RST_WEL;
            next_c.bp      = RST_BP;
            next_c.protect_pin_enable    = RST_PPE;
            next_c.cs_prev = RST_CS_N;
        end
    end

    always_ff @(posedge i_mclk) begin
        c <= next_c;
    end

    // status pins
    assign o_busy               = c.busy;
    assign o_write_latch        = c.wel;
    assign o_block_protect      = c.bp;
    assign o_protect_pin_enable = c.protect_pin_enable;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_arm_write;
        cs_rise && !byte_ev && c.st == ST_DATA && c.op == OPC_WRITE_ARRAY && c.wel && (|c.pmask)
            && !page_locked(c.bp, {c.page, 5'h00});
    endsequence

    sequence s_programming;
        c.busy && !c.wel ##1 c.busy [*8];
    endsequence

    a_write_launch: assert property (s_arm_write |=> s_programming)
        else $error("write did not start on select rising");
    a_busy_bound: assert property (c.busy |-> c.wr_cnt < 20'(WR_CYCLES))
        else $error("write cycle exceeded its time");
    a_busy_ends: assert property (c.busy && c.wr_cnt == 20'(WR_CYCLES - 1) |=> !c.busy)
        else $error("busy did not clear at end of write");
    a_latch_clear: assert property (cs_rise && !byte_ev && c.st == ST_DATA && c.op == OPC_CLR_LATCH |=> !c.wel)
        else $error("latch still set after clear command");
    a_hw_lock: assert property (cs_rise && c.st == ST_DATA && c.op == OPC_WRITE_STATUS && c.protect_pin_enable && !wp_s
        |=> $stable(c.bp) && c.protect_pin_enable)
        else $error("protect bits changed under hardware lock");
    a_busy_skip: assert property (byte_ev && c.st == ST_OPC && c.busy
        && (lr.rx_byte & OPC_MASK) != OPC_READ_STATUS && !cs_rise |=> c.st == ST_SKIP)
        else $error("command accepted while busy");
    a_status_busy: assert property (seven_ev && c.busy && c.st == ST_DATA && c.op == OPC_READ_STATUS
        |=> c.tx_even == STATUS_BUSY_VAL && c.tx_odd == STATUS_BUSY_VAL)
        else $error("busy status not staged");
    a_reset_idle: assert property (@(posedge i_mclk) disable iff (1'b0)
        i_rst |=> c.st == ST_IDLE && !c.wel && !c.busy)
        else $error("reset did not return to standby");
    a_page_wrap: assert property (c.mem_we |-> c.mem_waddr[12:5] == c.page && c.busy)
        else $error("programming left the page");
    a_opcode_first: assert property (byte_ev && c.st == ST_OPC && !cs_rise |=> c.st != ST_OPC)
        else $error("opcode byte not decoded");

endmodule // eeprom_spi_slave

// ===== spi_host_model.sv
// serial master model driving the memory slave's link pins
`timescale 1ns/10ps
module spi_host_model (
    // link pins
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    output logic      o_hold_n,
    // data back from the slave
    input  wire logic i_so
);
    logic cpol;
    // idle: deselected, clock parked low
    initial begin
        o_cs_n   = 1'b1;
        o_sck    = 1'b0;
        o_si     = 1'b0;
        o_hold_n = 1'b1;
        cpol     = 1'b0;
    end
    // select falls with the clock at its idle level
    task automatic start(input logic m3);
        cpol  = m3;
        o_sck = m3;
        #100 o_cs_n = 1'b0;
        #60;
    endtask
    // one byte each way, msb first, 125 ns per bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_sck = 1'b0;
            o_si  = tx[i];
            #62.5 o_sck = 1'b1;
            rx[i] = i_so;
            #62.5;
        end
    endtask
    // park the clock, deselect, data line drifts
    task automatic stop();
        #30 o_sck = cpol;
        #30 o_cs_n = 1'b1;
        o_si = ~o_si;
    endtask
    // suspend while clock low; clock and data toggle meanwhile
    task automatic pause();
        o_sck = 1'b0;
        #30 o_hold_n = 1'b0;
        repeat (3) begin
            #62.5 o_sck = 1'b1;
            o_si = ~o_si;
            #62.5 o_sck = 1'b0;
        end
        #30 o_hold_n = 1'b1;
        #30;
    endtask
endmodule // spi_host_model

// ===== serial_eeprom_slave_interface_test.sv
// self-checking bench for the serial memory slave
`timescale 1ns/10ps
module serial_eeprom_slave_interface_test;
    import eeprom_spi_pkg::*;
    localparam int WRC = 400;
    logic        mclk, rst, wp_n, cs_n, sck, si, hold_n, so, so_oe, busy, wl, ppe, so_line;
    logic [1:0]  bp, b;
    logic [7:0]  q[$], rx, d[8];
    logic [12:0] a;
    int          n_fail = 0, n_checks = 0, cyc = 0, seed, hold_at;

    eeprom_spi_slave #(.WR_CYCLES(WRC)) u_dut (
        .i_mclk(mclk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
        .i_hold_n(hold_n), .i_wp_n(wp_n), .o_busy(busy), .o_write_latch(wl), .o_block_protect(bp),
        .o_protect_pin_enable(ppe));
    spi_host_model u_host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n), .i_so(so_line));
    // released line shows the inverse of the last driven bit
    assign so_line = so_oe ? so : ~so;

    // system clock, 10 ns
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one frame from q, last byte back in rx
    task automatic send(input logic m3);
        u_host.start(m3);
        foreach (q[i]) begin
            if (i == hold_at)
                u_host.pause();
            u_host.xfer(q[i], rx);
        end
        u_host.stop();
        #20;
        chk("so_oe", 8'h00, {7'h00, so_oe});
    endtask
    task automatic status(input logic m3, input logic [7:0] exp);
        q = '{OPC_READ_STATUS, 8'h00};
        send(m3);
        chk("status", exp, rx);
    endtask
    // expected status byte when idle
    function automatic logic [7:0] stat_byte(input logic pe, input logic [1:0] p, input logic l);
        return {pe, 3'h0, p, l, 1'b0};
    endfunction
    // only defined opcodes are sent, one of them with its don't-care bit set
    task automatic op(input logic [7:0] c);
        q = '{c};
        send(1'b0);
    endtask
    // array command header, upper address bits random
    task automatic arr(input logic [7:0] c, input logic [12:0] ad);
        q = '{c, {3'($random(seed)), ad[12:8]}, ad[7:0]};
    endtask
    // write cycle: busy soon after select rises, ends after WRC
    task automatic wr_done(input logic rd);
        int t0;
        t0 = cyc;
        repeat (6) @(posedge mclk);
        chk("busy", 8'h01, {7'h00, busy});
        if (rd) begin
            status(1'b0, STATUS_BUSY_VAL);
            op(OPC_SET_LATCH);
        end
        while (cyc < t0 + WRC - 6)
            @(posedge mclk);
        chk("busy held", 8'h01, {7'h00, busy});
        repeat (12) @(posedge mclk);
        chk("busy end", 8'h00, {7'h00, busy});
        if (rd)
            status(1'b0, 8'h00);
    endtask
    task automatic wstat(input logic m3, input logic [7:0] v);
        op(OPC_SET_LATCH);
        q = '{OPC_WRITE_STATUS, v};
        send(m3);
        wr_done(1'b0);
    endtask

    // main sequence
    initial begin
        seed = 97440;
        hold_at = -1;
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (5) @(posedge mclk);
        chk("flags", 8'h00, {busy, wl, bp, ppe, 3'h0});
        status(1'b0, 8'h00);
        op(OPC_SET_LATCH);
        status(1'b1, stat_byte(1'b0, 2'h0, 1'b1));
        chk("latch pin", 8'h01, {7'h00, wl});
        op(OPC_CLR_LATCH | 8'h08);
        status(1'b0, 8'h00);
        b = 2'($random(seed));
        wstat(1'b0, stat_byte(1'b1, b, 1'b0));
        status(1'b1, stat_byte(1'b1, b, 1'b0));
        chk("protect pins", stat_byte(1'b1, b, 1'b0), stat_byte(ppe, bp, wl));
        @(posedge mclk) wp_n <= 1'b0;
        wstat(1'b1, 8'h00);
        status(1'b0, stat_byte(1'b1, b, 1'b0));
        @(posedge mclk) wp_n <= 1'b1;
        wstat(1'b0, 8'h00);
        status(1'b0, 8'h00);
        // eight bytes from a column of 28 to 31 wrap in the page, with a pause
        a = 13'($random(seed)) | 13'h001C;
        for (int i = 0; i < 8; i++)
            d[i] = 8'($random(seed));
        op(OPC_SET_LATCH);
        arr(OPC_WRITE_ARRAY, a);
        foreach (d[i])
            q.push_back(d[i]);
        hold_at = 5;
        send(1'b0);
        hold_at = -1;
        wr_done(1'b1);
        // whole array locked: a write is dropped
        wstat(1'b0, 8'h0C);
        op(OPC_SET_LATCH);
        arr(OPC_WRITE_ARRAY, a);
        q.push_back(~d[0]);
        send(1'b1);
        repeat (WRC + 20) @(posedge mclk);
        wstat(1'b0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            arr(OPC_READ_ARRAY, {a[12:5], 5'(a[4:0] + i)});
            q.push_back(8'h00);
            send(i[0]);
            chk("data", d[i], rx);
        end
        end_of_test();
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
endmodule // serial_eeprom_slave_interface_test
